// *** hw/bdl_agen.sv ***
// address generator: offset address and access address
`timescale 1ns/1ps
`default_nettype none

module bdl_agen #(
  parameter int W = 32
) (
  input wire logic [W-1:0] base,
  input wire logic [W-1:0] offset,
  input wire logic add,
  input wire logic index,
  output logic [W-1:0] offs_addr,
  output logic [W-1:0] addr
);

  // ---------------------------------------------------------------
  // add or subtract, then pick pre- or post-index address
  // ---------------------------------------------------------------
  assign offs_addr = add ? base + offset : base - offset;
  assign addr = index ? offs_addr : base;

endmodule // bdl_agen

`default_nettype wire

// *** hw/bdl_exec.sv ***
// byte load and two-word load decode and execute unit with ahb-lite regs
//
// Functional notes
// - register offset shifted 0-3, byte zero-extended
// - short encoding always uses shift zero
// - unprivileged byte load uses unprivileged rights
// - unprivileged: base plus eight_bit_offset, no writeback
// - unprivileged form, base all ones: hand off
// - dual: index, add, writeback flags; imm times four
// - dual with index and write clear: hand off
// - dual unpredictable register combinations flagged
// - dual loads two words, optional writeback
// - dual with base all ones is pc-relative
// - pc-relative dual needs word-aligned pc
// - pc-relative dual uses raw pc, write unpredictable
// - failed condition changes no state
// - long byte form: bad destination/offset registers
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module bdl_exec (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic iss_valid,
  input wire bdl_pkg::bdl_iss_t iss,
  output logic iss_ready,
  output logic [3:0] rf_raddr_a,
  output logic [3:0] rf_raddr_b,
  input wire logic [31:0] rf_rdata_a,
  input wire logic [31:0] rf_rdata_b,
  output bdl_pkg::bdl_mem_req_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output bdl_pkg::bdl_wr_t wr,
  output logic done,
  output bdl_pkg::bdl_res_t result
);

  bdl_pkg::bdl_state_t st_r;
  bdl_pkg::bdl_state_t st_nxt;
  bdl_pkg::bdl_dec_t dec;
  logic [15:0] hw1;
  logic [15:0] hw2;
  logic accept;
  logic is_dual;
  logic bad_pair;
  logic [31:0] ag_base;
  logic [31:0] ag_off;
  logic [31:0] ag_offs;
  logic [31:0] ag_addr;
  logic [31:0] rd_val;

  assign hw1 = iss.instr[31:16];
  assign hw2 = iss.instr[15:0];
  assign accept = iss_valid && st_r.iss_ready;
  assign is_dual = st_r.op == bdl_pkg::BDL_OP_DUAL_IMM
                || st_r.op == bdl_pkg::BDL_OP_DUAL_LIT;
  assign bad_pair = hw2[15:12] == bdl_pkg::BDL_REG_SP
                 || hw2[15:12] == bdl_pkg::BDL_REG_PC
                 || hw2[11:8] == bdl_pkg::BDL_REG_SP
                 || hw2[11:8] == bdl_pkg::BDL_REG_PC
                 || hw2[15:12] == hw2[11:8];

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  // decode straight off the issue port; captured only on accept
  always_comb
  begin
    dec = '0;
    dec.op = bdl_pkg::BDL_OP_NONE;
    dec.res = bdl_pkg::BDL_RES_FOREIGN;
    dec.add = 1'h1;
    dec.index = 1'h1;
    if (!iss.wide)
    begin
      if (hw2[15:9] == bdl_pkg::BDL_ENC_BREG_T1)
      begin
        dec.op = bdl_pkg::BDL_OP_BYTE_REG;
        dec.offset_register = {1'h0, hw2[8:6]};
        dec.base_register = {1'h0, hw2[5:3]};
        dec.first_destination = {1'h0, hw2[2:0]};
        dec.shift = 2'h0;
      end
    end
    else if (hw1[15:4] == bdl_pkg::BDL_ENC_BYTE_W)
    begin
      dec.base_register = hw1[3:0];
      dec.first_destination = hw2[15:12];
      if (hw1[3:0] == bdl_pkg::BDL_REG_PC)
        dec.res = bdl_pkg::BDL_RES_HAND_BLIT;
      else if (hw2[11:6] == bdl_pkg::BDL_ENC_BREG_W)
      begin
        // destination pc here is a preload hint, not ours
        if (hw2[15:12] != bdl_pkg::BDL_REG_PC)
          dec.op = bdl_pkg::BDL_OP_BYTE_REG;
        dec.offset_register = hw2[3:0];
        dec.shift = hw2[5:4];
        dec.unpred = hw2[15:12] == bdl_pkg::BDL_REG_SP
                  || hw2[3:0] == bdl_pkg::BDL_REG_SP
                  || hw2[3:0] == bdl_pkg::BDL_REG_PC;
      end
      else if (hw2[11:8] == bdl_pkg::BDL_ENC_BUNPRIV)
      begin
        dec.op = bdl_pkg::BDL_OP_BYTE_UNPRIV;
        dec.imm = {2'h0, hw2[7:0]};
        dec.unpred = hw2[15:12] == bdl_pkg::BDL_REG_SP
                  || hw2[15:12] == bdl_pkg::BDL_REG_PC;
      end
    end
    else if (hw1[15:9] == bdl_pkg::BDL_ENC_DUAL_HI && hw1[6] && hw1[4])
    begin
      dec.base_register = hw1[3:0];
      dec.first_destination = hw2[15:12];
      dec.second_destination = hw2[11:8];
      dec.imm = {hw2[7:0], 2'h0};
      dec.index = hw1[8];
      dec.add = hw1[7];
      dec.wback = hw1[5];
      if (!hw1[8] && !hw1[5])
        dec.res = bdl_pkg::BDL_RES_HAND_DUAL;
      else if (hw1[3:0] == bdl_pkg::BDL_REG_PC)
      begin
        // the pc is never written back, even when asked for
        dec.op = bdl_pkg::BDL_OP_DUAL_LIT;
        dec.index = 1'h1;
        dec.wback = 1'h0;
        dec.unpred = bad_pair || hw1[5]
                  || iss.pc[1:0] != 2'h0;
      end
      else
      begin
        dec.op = bdl_pkg::BDL_OP_DUAL_IMM;
        dec.unpred = bad_pair || (hw1[5]
                  && (hw1[3:0] == hw2[15:12]
                  || hw1[3:0] == hw2[11:8]));
      end
    end
    if (dec.op != bdl_pkg::BDL_OP_NONE)
    begin
      if (!iss.cond_pass)
        dec.res = bdl_pkg::BDL_RES_CFAIL;
      else if (dec.unpred && st_r.skip)
        dec.res = bdl_pkg::BDL_RES_UNPRED;
      else
        dec.res = bdl_pkg::BDL_RES_OK;
      dec.exec = iss.cond_pass && !(dec.unpred && st_r.skip);
    end
  end

  // ---------------------------------------------------------------
  // address generation
  // ---------------------------------------------------------------
  // literal form takes the pc as issued, not word-aligned
  assign ag_base = st_r.op == bdl_pkg::BDL_OP_DUAL_LIT ? st_r.pc
                                                       : rf_rdata_a;
  assign ag_off = st_r.op == bdl_pkg::BDL_OP_BYTE_REG
                ? rf_rdata_b << st_r.shift
                : {22'h0, st_r.imm};

  bdl_agen #(
    .W(32)
  ) u_agen (
    .base(ag_base),
    .offset(ag_off),
    .add(st_r.add),
    .index(st_r.index),
    .offs_addr(ag_offs),
    .addr(ag_addr)
  );

  // register read mux for the bus; unmapped offsets read zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (st_r.ph_addr)
      bdl_pkg::BDL_OFF_CTRL:
      begin
        rd_val[bdl_pkg::BDL_CTRL_EN_BIT] = st_r.en;
        rd_val[bdl_pkg::BDL_CTRL_SKIP_BIT] = st_r.skip;
      end
      bdl_pkg::BDL_OFF_STATUS:
      begin
        rd_val[bdl_pkg::BDL_STAT_BUSY_BIT] = st_r.fsm != bdl_pkg::BDL_IDLE;
        rd_val[bdl_pkg::BDL_STAT_UNPRED_BIT] = st_r.sticky;
        rd_val[bdl_pkg::BDL_STAT_RES_LSB +: 3] = st_r.last_res;
      end
      bdl_pkg::BDL_OFF_COUNT: rd_val = {16'h0000, st_r.count};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // next state: bus slave and execute sequence
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'h0;
    st_nxt.wr.en = 1'h0;
    // write data phase; status bit is write-one-to-clear
    if (st_r.ph_write)
    begin
      if (st_r.ph_addr == bdl_pkg::BDL_OFF_CTRL)
      begin
        st_nxt.en = hwdata[bdl_pkg::BDL_CTRL_EN_BIT];
        st_nxt.skip = hwdata[bdl_pkg::BDL_CTRL_SKIP_BIT];
      end
      if (st_r.ph_addr == bdl_pkg::BDL_OFF_STATUS
          && hwdata[bdl_pkg::BDL_STAT_UNPRED_BIT])
        st_nxt.sticky = 1'h0;
    end
    // reads take one wait state so a write just before is seen
    if (st_r.ph_rd)
    begin
      st_nxt.hrdata = rd_val;
      st_nxt.hreadyout = 1'h1;
      st_nxt.ph_rd = 1'h0;
    end
    st_nxt.ph_write = 1'h0;
    if (hsel && hready && htrans[1])
    begin
      st_nxt.ph_addr = haddr[7:0];
      st_nxt.ph_write = hwrite;
      if (!hwrite)
      begin
        st_nxt.ph_rd = 1'h1;
        st_nxt.hreadyout = 1'h0;
      end
    end
    case (st_r.fsm)
      bdl_pkg::BDL_IDLE:
      begin
        if (accept)
        begin
          st_nxt.op = dec.op;
          st_nxt.first_destination = dec.first_destination;
          st_nxt.second_destination = dec.second_destination;
          st_nxt.base_register = dec.base_register;
          st_nxt.shift = dec.shift;
          st_nxt.imm = dec.imm;
          st_nxt.add = dec.add;
          st_nxt.index = dec.index;
          st_nxt.wback = dec.wback;
          st_nxt.priv = iss.priv;
          st_nxt.pc = iss.pc;
          st_nxt.rd_a = dec.base_register;
          st_nxt.rd_b = dec.offset_register;
          // set after any clear above, so a new event is never lost;
          // a preload or foreign encoding never marks the flag
          if (dec.unpred && iss.cond_pass && dec.op != bdl_pkg::BDL_OP_NONE)
            st_nxt.sticky = 1'h1;
          if (dec.exec)
            st_nxt.fsm = bdl_pkg::BDL_OPER;
          else
          begin
            st_nxt.done = 1'h1;
            st_nxt.result = dec.res;
            st_nxt.last_res = dec.res;
          end
        end
      end
      bdl_pkg::BDL_OPER:
      begin
        st_nxt.mem.req = 1'h1;
        st_nxt.mem.addr = ag_addr;
        st_nxt.mem.word = is_dual;
        st_nxt.mem.unpriv = st_r.op == bdl_pkg::BDL_OP_BYTE_UNPRIV
                         || !st_r.priv;
        st_nxt.offs_addr = ag_offs;
        st_nxt.fsm = bdl_pkg::BDL_MEM1;
      end
      bdl_pkg::BDL_MEM1:
      begin
        if (mem_ack)
        begin
          st_nxt.wr.en = 1'h1;
          st_nxt.wr.idx = st_r.first_destination;
          st_nxt.wr.data = is_dual ? mem_rdata
                                   : {24'h00_0000, mem_rdata[7:0]};
          st_nxt.mem.req = is_dual;
          st_nxt.mem.addr = st_r.mem.addr + bdl_pkg::BDL_WORD_STEP;
          st_nxt.fsm = is_dual ? bdl_pkg::BDL_MEM2 : bdl_pkg::BDL_IDLE;
        end
      end
      bdl_pkg::BDL_MEM2:
      begin
        if (mem_ack)
        begin
          st_nxt.wr.en = 1'h1;
          st_nxt.wr.idx = st_r.second_destination;
          st_nxt.wr.data = mem_rdata;
          st_nxt.mem.req = 1'h0;
          st_nxt.fsm = st_r.wback ? bdl_pkg::BDL_WB : bdl_pkg::BDL_IDLE;
        end
      end
      bdl_pkg::BDL_WB:
      begin
        st_nxt.wr.en = 1'h1;
        st_nxt.wr.idx = st_r.base_register;
        st_nxt.wr.data = st_r.offs_addr;
        st_nxt.fsm = bdl_pkg::BDL_IDLE;
      end
      default: st_nxt.fsm = bdl_pkg::BDL_IDLE;
    endcase
    // completion of an executed load
    if (st_r.fsm != bdl_pkg::BDL_IDLE && st_nxt.fsm == bdl_pkg::BDL_IDLE)
    begin
      st_nxt.done = 1'h1;
      st_nxt.result = bdl_pkg::BDL_RES_OK;
      st_nxt.last_res = bdl_pkg::BDL_RES_OK;
      st_nxt.count = st_r.count + 16'h0001;
    end
    st_nxt.iss_ready = st_nxt.fsm == bdl_pkg::BDL_IDLE && st_nxt.en;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= '0;
      st_r.en <= bdl_pkg::BDL_CTRL_EN_RST;
      st_r.skip <= bdl_pkg::BDL_CTRL_SKIP_RST;
      st_r.iss_ready <= bdl_pkg::BDL_CTRL_EN_RST;
      st_r.hreadyout <= bdl_pkg::BDL_HREADY_RST;
    end
    else
      st_r <= st_nxt;
  end

  // outputs, all straight from the state register
  assign hreadyout = st_r.hreadyout;
  assign hrdata = st_r.hrdata;
  assign hresp = st_r.hresp;
  assign iss_ready = st_r.iss_ready;
  assign rf_raddr_a = st_r.rd_a;
  assign rf_raddr_b = st_r.rd_b;
  assign mem = st_r.mem;
  assign wr = st_r.wr;
  assign done = st_r.done;
  assign result = st_r.result;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_byte_zero_ext: assert property (
    st_r.fsm == bdl_pkg::BDL_MEM1 && mem_ack && !is_dual
    |=> wr.en && wr.data == {24'h00_0000, $past(mem_rdata[7:0])})
    else $error("byte load not zero-extended");
  a_byte_reg_addr: assert property (
    st_r.fsm == bdl_pkg::BDL_OPER && st_r.op == bdl_pkg::BDL_OP_BYTE_REG
    |=> mem.req && mem.addr == $past(rf_rdata_a)
        + ($past(rf_rdata_b) << $past(st_r.shift)))
    else $error("register offset address wrong");
  a_short_shift: assert property (
    accept && !iss.wide && dec.op == bdl_pkg::BDL_OP_BYTE_REG
    |=> st_r.shift == 2'h0)
    else $error("short form shift not zero");
  a_unpriv_rights: assert property (
    mem.req && st_r.op == bdl_pkg::BDL_OP_BYTE_UNPRIV |-> mem.unpriv)
    else $error("unprivileged load used privileged rights");
  a_unpriv_addr: assert property (
    st_r.fsm == bdl_pkg::BDL_OPER && st_r.op == bdl_pkg::BDL_OP_BYTE_UNPRIV
    |=> mem.addr == $past(rf_rdata_a) + {22'h0, $past(st_r.imm)}
        ##1 st_r.fsm != bdl_pkg::BDL_WB)
    else $error("unprivileged load address or writeback wrong");
  a_hand_off: assert property (
    accept && (dec.res == bdl_pkg::BDL_RES_HAND_BLIT
               || dec.res == bdl_pkg::BDL_RES_HAND_DUAL)
    |=> done && result == $past(dec.res) && st_r.fsm == bdl_pkg::BDL_IDLE)
    else $error("hand-off encoding was executed");
  a_dual_imm_scale: assert property (
    accept && dec.op == bdl_pkg::BDL_OP_DUAL_IMM
    |=> st_r.imm == {$past(iss.instr[7:0]), 2'h0}
        && st_r.index == $past(iss.instr[24]))
    else $error("dual immediate fields wrong");
  a_dual_second: assert property (
    st_r.fsm == bdl_pkg::BDL_MEM1 && mem_ack && is_dual
    |=> mem.req && mem.addr == $past(mem.addr) + 32'h0000_0004)
    else $error("second word address wrong");
  a_lit_align: assert property (
    accept && iss.cond_pass && dec.op == bdl_pkg::BDL_OP_DUAL_LIT
    && iss.pc[1:0] != 2'h0 |=> st_r.sticky)
    else $error("misaligned pc not flagged");
  a_lit_addr: assert property (
    st_r.fsm == bdl_pkg::BDL_OPER && st_r.op == bdl_pkg::BDL_OP_DUAL_LIT
    |=> mem.addr == ($past(st_r.add)
        ? $past(st_r.pc) + {22'h0, $past(st_r.imm)}
        : $past(st_r.pc) - {22'h0, $past(st_r.imm)}))
    else $error("pc-relative address wrong");
  a_cond_fail: assert property (
    accept && !iss.cond_pass && dec.op != bdl_pkg::BDL_OP_NONE
    |=> done && result == bdl_pkg::BDL_RES_CFAIL && !wr.en && !mem.req)
    else $error("failed condition changed state");
  a_long_unpred: assert property (
    accept && iss.wide && dec.op == bdl_pkg::BDL_OP_BYTE_REG
    && iss.cond_pass && hw2[3:0] == bdl_pkg::BDL_REG_PC |=> st_r.sticky)
    else $error("bad offset register not flagged");

  c_byte_done: cover property (st_r.op == bdl_pkg::BDL_OP_BYTE_REG && done);
  c_unpriv_done: cover property (
    st_r.op == bdl_pkg::BDL_OP_BYTE_UNPRIV && done);
  c_dual_wb: cover property (st_r.fsm == bdl_pkg::BDL_WB);
  c_cond_fail: cover property (done && result == bdl_pkg::BDL_RES_CFAIL);

endmodule // bdl_exec

`default_nettype wire

// *** hw/bdl_pkg.sv ***
// package: constants and types for the byte and dual load execute block
package bdl_pkg;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] BDL_OFF_CTRL = 8'h00;
  localparam logic [7:0] BDL_OFF_STATUS = 8'h04;
  localparam logic [7:0] BDL_OFF_COUNT = 8'h08;
  localparam int BDL_CTRL_EN_BIT = 0;
  localparam int BDL_CTRL_SKIP_BIT = 1;
  localparam int BDL_STAT_BUSY_BIT = 0;
  localparam int BDL_STAT_UNPRED_BIT = 1;
  localparam int BDL_STAT_RES_LSB = 4;
  localparam logic BDL_CTRL_EN_RST = 1'h1;
  localparam logic BDL_CTRL_SKIP_RST = 1'h0;
  localparam logic BDL_HREADY_RST = 1'h1;

  // ---------------------------------------------------------------
  // encodings and register numbers
  // ---------------------------------------------------------------
  localparam logic [6:0] BDL_ENC_BREG_T1 = 7'h2e;
  localparam logic [11:0] BDL_ENC_BYTE_W = 12'hf81;
  localparam logic [5:0] BDL_ENC_BREG_W = 6'h00;
  localparam logic [3:0] BDL_ENC_BUNPRIV = 4'he;
  localparam logic [6:0] BDL_ENC_DUAL_HI = 7'h74;
  localparam logic [3:0] BDL_REG_SP = 4'hd;
  localparam logic [3:0] BDL_REG_PC = 4'hf;
  localparam logic [31:0] BDL_WORD_STEP = 32'h0000_0004;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BDL_IDLE = 3'b000,
    BDL_OPER = 3'b001,
    BDL_MEM1 = 3'b010,
    BDL_MEM2 = 3'b011,
    BDL_WB = 3'b100
  } bdl_fsm_t;

  typedef enum logic [2:0] {
    BDL_OP_NONE = 3'b000,
    BDL_OP_BYTE_REG = 3'b001,
    BDL_OP_BYTE_UNPRIV = 3'b010,
    BDL_OP_DUAL_IMM = 3'b011,
    BDL_OP_DUAL_LIT = 3'b100
  } bdl_op_t;

  typedef enum logic [2:0] {
    BDL_RES_OK = 3'b000,
    BDL_RES_CFAIL = 3'b001,
    BDL_RES_UNPRED = 3'b010,
    BDL_RES_HAND_BLIT = 3'b011,
    BDL_RES_HAND_DUAL = 3'b100,
    BDL_RES_FOREIGN = 3'b101
  } bdl_res_t;

  typedef struct packed {
    logic [31:0] instr;
    logic wide;
    logic cond_pass;
    logic priv;
    logic [31:0] pc;
  } bdl_iss_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic word;
    logic unpriv;
  } bdl_mem_req_t;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } bdl_wr_t;

  typedef struct packed {
    bdl_op_t op;
    bdl_res_t res;
    logic exec;
    logic unpred;
    logic [3:0] first_destination;
    logic [3:0] second_destination;
    logic [3:0] base_register;
    logic [3:0] offset_register;
    logic [1:0] shift;
    logic [9:0] imm;
    logic add;
    logic index;
    logic wback;
  } bdl_dec_t;

  typedef struct packed {
    bdl_fsm_t fsm;
    bdl_op_t op;
    logic [3:0] first_destination;
    logic [3:0] second_destination;
    logic [3:0] base_register;
    logic [1:0] shift;
    logic [9:0] imm;
    logic add;
    logic index;
    logic wback;
    logic priv;
    logic [31:0] pc;
    logic [31:0] offs_addr;
    logic [3:0] rd_a;
    logic [3:0] rd_b;
    logic en;
    logic skip;
    logic sticky;
    logic [15:0] count;
    bdl_res_t last_res;
    logic iss_ready;
    bdl_mem_req_t mem;
    bdl_wr_t wr;
    logic done;
    bdl_res_t result;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic ph_write;
    logic ph_rd;
    logic [7:0] ph_addr;
  } bdl_state_t;

endpackage

// *** verif/bdl_mem_model.sv ***
// memory system model answering the block's load requests
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// memory partner
// ------------------------------------------------------------
module bdl_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire bdl_pkg::bdl_mem_req_t mem,
  input wire logic [1:0] delay,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [1:0] wait_r;

  // ack delay+1 cycles after the request; data is the inverted address, upper bits set
  // so a missing zero-extension shows; idle data toggles, never stale
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5a5a_0f0f;
      wait_r <= 2'h0;
    end
    else if (mem.req && !mem_ack && wait_r >= delay)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= ~mem.addr;
      wait_r <= 2'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= {mem_rdata[30:0], ~mem_rdata[31]};
      wait_r <= (mem.req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
    end
endmodule // bdl_mem_model

`default_nettype wire

// *** verif/byte_and_dual_load_exec_bench.sv ***
// self-checking bench for the byte and two-word load execute block
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module byte_and_dual_load_exec_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, iss_valid, iss_ready;
  logic done, mem_ack;
  logic [1:0] htrans, delay;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata;
  logic [3:0] rf_raddr_a, rf_raddr_b;
  logic [31:0] rf [16];
  bdl_pkg::bdl_iss_t iss;
  bdl_pkg::bdl_mem_req_t mem;
  bdl_pkg::bdl_wr_t wr;
  bdl_pkg::bdl_res_t result, res;
  int n_fail, samples_checked, n_acc, n_wr, cycles;
  logic [31:0] acc_a [4];
  logic acc_u [4];
  logic acc_w [4];
  logic [3:0] wr_i [4];
  logic [31:0] wr_d [4];
  wire logic [31:0] rf_a = rf[rf_raddr_a];
  wire logic [31:0] rf_b = rf[rf_raddr_b];

  // the one slave's hreadyout is the bus's hready
  bdl_exec dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .iss_valid, .iss,
    .iss_ready, .rf_raddr_a, .rf_raddr_b, .rf_rdata_a(rf_a),
    .rf_rdata_b(rf_b), .mem, .mem_ack, .mem_rdata, .wr, .done, .result
  );

  bdl_mem_model mem_model (
    .hclk, .hresetn, .mem, .delay, .mem_ack, .mem_rdata
  );

  // clock and hang guard; 5000 cycles is far above the whole sequence
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single ahb transfer; outputs looked at on the falling edge, where
  // they are settled, and acted on at the following rising edge
  task automatic ahb(logic wrt, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0000_00, a};
    hwrite <= wrt;
    @(negedge hclk);
    while (hreadyout !== 1'b1)
      @(negedge hclk);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(negedge hclk);
    while (hreadyout !== 1'b1)
      @(negedge hclk);
    q = hrdata;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk("register", exp, q);
    chk("response", 32'h0, {31'h0, hresp});
  endtask

  task automatic wrr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  // issue one instruction, log memory accesses and writes until done
  task automatic run(logic [31:0] ins, logic c, logic [31:0] pc);
    n_acc = 0;
    n_wr = 0;
    @(posedge hclk);
    iss_valid <= 1'b1;
    iss <= '{instr: ins, wide: ins[31:29] == 3'b111, cond_pass: c,
             priv: 1'b1, pc: pc};
    @(negedge hclk);
    while (iss_ready !== 1'b1)
      @(negedge hclk);
    @(posedge hclk);
    iss_valid <= 1'b0;
    do
    begin
      @(negedge hclk);
      if (mem.req === 1'b1 && mem_ack === 1'b1 && n_acc < 4)
      begin
        acc_a[n_acc] = mem.addr;
        acc_u[n_acc] = mem.unpriv;
        acc_w[n_acc] = mem.word;
        n_acc++;
      end
      if (wr.en === 1'b1 && n_wr < 4)
      begin
        wr_i[n_wr] = wr.idx;
        wr_d[n_wr] = wr.data;
        n_wr++;
      end
    end while (done !== 1'b1);
    res = result;
  endtask

  task automatic outcome(bdl_pkg::bdl_res_t r, int na, int nw);
    chk("result", 32'(r), 32'(res));
    chk("accesses", na, n_acc);
    chk("writes", nw, n_wr);
  endtask

  task automatic acc_is(int k, logic [31:0] a, logic u, logic w);
    chk("address", a, acc_a[k]);
    chk("rights and size", {30'h0, u, w}, {30'h0, acc_u[k], acc_w[k]});
  endtask

  task automatic wr_is(int k, logic [3:0] i, logic [31:0] d);
    chk("write index", {28'h0, i}, {28'h0, wr_i[k]});
    chk("write data", d, wr_d[k]);
  endtask

  task automatic t_byte();
    delay <= 2'h3;
    run(32'hf811_3032, 1'b1, 32'h0);
    outcome(bdl_pkg::BDL_RES_OK, 1, 1);
    acc_is(0, 32'h0000_1088, 1'b0, 1'b0);
    wr_is(0, 4'h3, 32'h0000_0077);
    run(32'h0000_5c8c, 1'b1, 32'h0);
    acc_is(0, 32'h0000_1011, 1'b0, 1'b0);
    wr_is(0, 4'h4, 32'h0000_00ee);
    run(32'hf811_5e80, 1'b1, 32'h0);
    outcome(bdl_pkg::BDL_RES_OK, 1, 1);
    acc_is(0, 32'h0000_1080, 1'b1, 1'b0);
    wr_is(0, 4'h5, 32'h0000_007f);
    $display("byte loads finished, mismatches %0d", n_fail);
  endtask

  task automatic t_dual();
    delay <= 2'h0;
    run(32'he971_67ff, 1'b1, 32'h0);
    outcome(bdl_pkg::BDL_RES_OK, 2, 3);
    acc_is(0, 32'h0000_0c04, 1'b0, 1'b1);
    acc_is(1, 32'h0000_0c08, 1'b0, 1'b1);
    wr_is(0, 4'h6, ~32'h0000_0c04);
    wr_is(1, 4'h7, ~32'h0000_0c08);
    wr_is(2, 4'h1, 32'h0000_0c04);
    run(32'he8f1_6701, 1'b1, 32'h0);
    acc_is(0, 32'h0000_1000, 1'b0, 1'b1);
    wr_is(2, 4'h1, 32'h0000_1004);
    run(32'he95f_8902, 1'b1, 32'h0000_2000);
    outcome(bdl_pkg::BDL_RES_OK, 2, 2);
    acc_is(1, 32'h0000_1ffc, 1'b0, 1'b1);
    wr_is(1, 4'h9, ~32'h0000_1ffc);
    run(32'he971_67ff, 1'b0, 32'h0);
    outcome(bdl_pkg::BDL_RES_CFAIL, 0, 0);
    run(32'he8d1_6701, 1'b1, 32'h0);
    outcome(bdl_pkg::BDL_RES_HAND_DUAL, 0, 0);
    run(32'hf81f_5e80, 1'b1, 32'h0);
    outcome(bdl_pkg::BDL_RES_HAND_BLIT, 0, 0);
    $display("two-word loads finished, mismatches %0d", n_fail);
  endtask

  // with skip set, each ill-formed encoding is refused without access
  task automatic t_skip();
    logic [31:0] ins [6] = '{32'he9d1_6601, 32'he95f_8902, 32'he97f_8902,
                             32'hf811_303d, 32'hf811_de80, 32'hf811_303f};
    logic [31:0] pcs [6] = '{32'h0, 32'h0000_2002, 32'h0000_2000,
                             32'h0, 32'h0, 32'h0};
    wrr(bdl_pkg::BDL_OFF_CTRL, 32'h0000_0003);
    for (int k = 0; k < 6; k++)
    begin
      run(ins[k], 1'b1, pcs[k]);
      outcome(bdl_pkg::BDL_RES_UNPRED, 0, 0);
    end
    rd(bdl_pkg::BDL_OFF_STATUS, 32'h0000_0022);
    // sticky flag is write-one-to-clear, last result stays
    wrr(bdl_pkg::BDL_OFF_STATUS, 32'h0000_0002);
    rd(bdl_pkg::BDL_OFF_STATUS, 32'h0000_0020);
    wrr(bdl_pkg::BDL_OFF_CTRL, 32'h0000_0000);
    @(negedge hclk);
    chk("issue gate", 32'h0, {31'h0, iss_ready});
    wrr(bdl_pkg::BDL_OFF_CTRL, 32'h0000_0001);
    rd(bdl_pkg::BDL_OFF_COUNT, 32'h0000_0006);
    $display("ill-formed encodings finished, mismatches %0d", n_fail);
  endtask

  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    iss_valid = 1'b0;
    iss = '0;
    delay = 2'h0;
    for (int k = 0; k < 16; k++)
      rf[k] = 32'h0000_0100 * k;
    rf[1] = 32'h0000_1000;
    rf[2] = 32'h0000_0011;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(bdl_pkg::BDL_OFF_CTRL, 32'h0000_0001);
    rd(bdl_pkg::BDL_OFF_COUNT, 32'h0000_0000);
    rd(8'h0c, 32'h0000_0000);
    t_byte();
    t_dual();
    t_skip();
    complete_run();
  end
endmodule // byte_and_dual_load_exec_bench

`default_nettype wire
